// File: include/flash_adc_params.svh
// Offsets, field positions, reset values and timing counts of the converter timing block
`ifndef FLASH_ADC_PARAMS_SVH
`define FLASH_ADC_PARAMS_SVH

// Register byte offsets
`define CTRL_OFF        8'h00
`define PIN_STATUS_OFF  8'h04
`define IRQ_STATUS_OFF  8'h08
`define IRQ_MASK_OFF    8'h0c
`define RESULT_OFF      8'h10

// Control fields
`define CTRL_CONV_EN_BIT 0
`define CTRL_RESET_VAL   32'h0000_0001

// Event bits, shared by status and mask
`define EV_DONE_BIT     0
`define EV_OVF_BIT      1
`define EV_RESERVED_BIT 2
`define EV_WIDTH        3
`define MASK_RESET_VAL  3'h0

// Pin status fields
`define PST_MODE_BIT    0
`define PST_PHASE_BIT   1
`define PST_VALID_BIT   2
`define PST_OPMODE_LSB  4

// Result fields
`define RES_OVF_BIT     6
`define RESULT_RESET_VAL 6'h00

// Timing: system clock period and aperture delay, in ns
`define CLK_PERIOD_NS   4
`define APERTURE_NS     25
`define APERTURE_CYC    ((`APERTURE_NS) / (`CLK_PERIOD_NS))

`endif

// File: include/flash_adc_pkg.sv
// Types shared by the converter timing block
package flash_adc_pkg;
  typedef enum logic [1:0] {
    OP_PIPELINED,
    OP_ONE_SHOT,
    OP_RESERVED
  } op_mode_e;
endpackage : flash_adc_pkg

// File: rtl/flash_adc_output_timing.sv
// Timing, encoding and output stage of a 6-bit flash converter, with an AHB-Lite register slave
// Functional notes
// [RULE_01] Encode comparator thermometer into 6-bit binary code
// [RULE_02] Separate comparator drives overflow flag output
// [RULE_03] Conversion synchronous, 1.5 sample clock periods
// [RULE_04] Latch-to-output transfer coincides with new sampling
// [RULE_05] Clock high balances, clock low samples
// [RULE_06] Rising edge ends sampling after aperture delay
// [RULE_07] Result held in D flip-flop output stage
// [RULE_08] Output enables act combinationally, clock independent
// [RULE_09] Global enable gates all; data needs low enable
// [RULE_10] Pipelined conversion spans three edges
// [RULE_11] Mode low, phase low: one-shot, two edges
// [RULE_12] Other side never applies reserved mode combination
// [RULE_13] Downstream flip-flop samples on falling edge
// [RULE_14] Downstream latch enabled during clock-high half
// [RULE_15] Above 2.5 MHz check outputs stable at capture
// [RULE_16] Mode high runs continuous pipelined conversion
// [RULE_17] Pipelined with phase high inverts phases
// [RULE_18] One-shot result updates at pulse end, holds
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_adc_params.svh"

module flash_adc_output_timing
  import flash_adc_pkg::*;
#(
  parameter int BITS   = 6,
  parameter int ADDR_W = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Converter pins
  input  wire logic                 sample_clk,
  input  wire logic                 mode_pipelined,
  input  wire logic                 phase_select,
  input  wire logic [(1<<BITS)-2:0] comparator_levels,
  input  wire logic                 overflow_comparator,
  input  wire logic                 data_output_enable_n,
  input  wire logic                 global_output_enable,
  output logic      [BITS-1:0]      conversion_result_bits,
  output logic                      conversion_result_oe,
  output logic                      overflow_flag,
  output logic                      overflow_flag_oe,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic      [31:0]          hrdata,
  output logic                      hresp,
  output logic                      irq
);

  localparam int TW   = (1 << BITS) - 1;  // Comparators below overflow
  localparam int SW   = TW + 4;           // Synchronised pin vector
  localparam int AP_D = `APERTURE_CYC;
  localparam logic [3:0] AP_LOAD = 4'(`APERTURE_CYC);

  // Thermometer to binary: ones are contiguous, so a count is the code
  function automatic logic [BITS-1:0] encode(input logic [TW-1:0] therm);
    logic [BITS-1:0] cnt;
    cnt = '0;
    for (int i = 0; i < TW; i++) begin
      if (therm[i]) begin
        cnt = cnt + BITS'(1);
      end
    end
    return cnt;
  endfunction : encode

  // Three-stage synchronisers; a bit counts once stages two and three agree
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] filt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {sample_clk, mode_pipelined, phase_select, overflow_comparator,
                comparator_levels};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Per-bit agreement filter
  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_filt
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          filt[g] <= 1'b0;
        end else if (sync2[g] == sync3[g]) begin
          filt[g] <= sync3[g];
        end
      end
    end
  endgenerate

  logic [TW-1:0] therm_f;
  logic          ovf_f;
  logic          phase_f;
  logic          mode_f;
  logic          clk_f;
  logic          clk_d;
  logic          rise_ev;
  logic          fall_ev;

  assign therm_f = filt[TW-1:0];
  assign ovf_f   = filt[TW];
  assign phase_f = filt[TW+1];
  assign mode_f  = filt[TW+2];
  assign clk_f   = filt[TW+3];

  // Edge detection on the filtered sample clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= clk_f;
    end
  end

  assign rise_ev = clk_f & ~clk_d;
  assign fall_ev = ~clk_f & clk_d;

  // Operating mode from mode and phase pins
  op_mode_e op_mode;
  always_comb begin
    if (mode_f) begin
      op_mode = OP_PIPELINED;                   // RULE_16
    end else if (phase_f) begin
      op_mode = OP_RESERVED;                    // RULE_12
    end else begin
      op_mode = OP_ONE_SHOT;                    // RULE_11
    end
  end

  logic ctrl_conv_en;
  logic sample_end;
  logic sample_start;

  // Sample phase ends on rising edge; in pipelined mode phase high swaps the halves
  always_comb begin
    sample_end   = 1'b0;
    sample_start = 1'b0;
    if (ctrl_conv_en) begin
      unique case (op_mode)
        OP_PIPELINED: begin
          sample_end   = phase_f ? fall_ev : rise_ev;   // RULE_05 RULE_17
          sample_start = phase_f ? rise_ev : fall_ev;
        end
        OP_ONE_SHOT: begin
          sample_end   = rise_ev;                       // RULE_06
        end
        OP_RESERVED: begin
          sample_end   = 1'b0;                          // No valid operation
        end
      endcase
    end
  end

  // Aperture delay: comparators disconnect a fixed time after the edge
  logic [3:0] ap_cnt;
  logic       capture;
  assign capture = (ap_cnt == 4'h1);  // RULE_03

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ap_cnt <= 4'h0;
    end else if (sample_end) begin
      ap_cnt <= AP_LOAD;                        // RULE_06
    end else if (ap_cnt != 4'h0) begin
      ap_cnt <= ap_cnt - 4'h1;
    end
  end

  // Comparator latches and output flip-flop stage
  logic [TW-1:0] comp_latch;
  logic          ovf_latch;
  logic          result_valid;
  logic          load_out;
  logic          pipe_mode;

  assign pipe_mode = (op_mode == OP_PIPELINED);
  // Pipelined loads on the next sample start; one-shot on its own capture
  assign load_out  = pipe_mode ? sample_start : (capture && op_mode == OP_ONE_SHOT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      comp_latch <= '0;
      ovf_latch  <= 1'b0;
    end else if (capture) begin
      comp_latch <= therm_f;
      ovf_latch  <= ovf_f;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversion_result_bits <= `RESULT_RESET_VAL;
      overflow_flag          <= 1'b0;
      result_valid           <= 1'b0;
    end else if (load_out) begin
      if (pipe_mode) begin
        conversion_result_bits <= encode(comp_latch);  // RULE_04 RULE_10 RULE_01
        overflow_flag          <= ovf_latch;           // RULE_02
      end else begin
        conversion_result_bits <= encode(therm_f);     // RULE_18 RULE_11
        overflow_flag          <= ovf_f;
      end
      result_valid <= 1'b1;                            // RULE_07
    end
  end

  // Buffers follow the enable pins with no clock in the path
  assign overflow_flag_oe     = global_output_enable;                          // RULE_08
  assign conversion_result_oe = global_output_enable & ~data_output_enable_n;  // RULE_09

  // Interrupt events; set wins over a same-cycle clear
  logic [`EV_WIDTH-1:0] ev;
  logic [`EV_WIDTH-1:0] irq_status;
  logic [`EV_WIDTH-1:0] irq_mask;
  logic [`EV_WIDTH-1:0] w1c;

  always_comb begin
    ev = '0;
    ev[`EV_DONE_BIT]     = load_out;
    ev[`EV_OVF_BIT]      = load_out & (pipe_mode ? ovf_latch : ovf_f);
    ev[`EV_RESERVED_BIT] = (op_mode == OP_RESERVED) & (rise_ev | fall_ev);
  end

  // AHB-Lite address phase capture; slave never waits
  logic              wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic              accept;
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= accept & hwrite;
      wr_addr <= haddr;
    end
  end

  assign w1c = (wr_pend && wr_addr == `IRQ_STATUS_OFF) ? hwdata[`EV_WIDTH-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~w1c) | ev;
    end
  end

  // Software-steered registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_conv_en <= 1'(`CTRL_RESET_VAL >> `CTRL_CONV_EN_BIT);
      irq_mask     <= `MASK_RESET_VAL;
    end else if (wr_pend) begin
      if (wr_addr == `CTRL_OFF) begin
        ctrl_conv_en <= hwdata[`CTRL_CONV_EN_BIT];
      end
      if (wr_addr == `IRQ_MASK_OFF) begin
        irq_mask <= hwdata[`EV_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data registered at the address phase; unmapped reads as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (haddr)
      `CTRL_OFF: rd_mux[`CTRL_CONV_EN_BIT] = ctrl_conv_en;
      `PIN_STATUS_OFF: begin
        rd_mux[`PST_MODE_BIT]  = mode_f;
        rd_mux[`PST_PHASE_BIT] = phase_f;
        rd_mux[`PST_VALID_BIT] = result_valid;
        rd_mux[`PST_OPMODE_LSB +: 2] = op_mode;
      end
      `IRQ_STATUS_OFF: rd_mux[`EV_WIDTH-1:0] = irq_status;
      `IRQ_MASK_OFF:   rd_mux[`EV_WIDTH-1:0] = irq_mask;
      `RESULT_OFF: begin
        rd_mux[BITS-1:0]     = conversion_result_bits;
        rd_mux[`RES_OVF_BIT] = overflow_flag;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (accept && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // Checks
  sequence s_sample_end;
    sample_end;
  endsequence

  sequence s_capture;
    capture;
  endsequence

  a_aperture_delay: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    s_sample_end |-> ##AP_D s_capture)
    else $error("capture not at aperture delay after sample end");

  a_pipe_transfer: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
    (pipe_mode && sample_start) |=> conversion_result_bits == encode($past(comp_latch)))
    else $error("pipelined output not loaded from latch");

  a_encode_code: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    (load_out && !pipe_mode) |=> conversion_result_bits == encode($past(therm_f)))
    else $error("one-shot code does not match comparators");

  a_overflow_path: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    (load_out && pipe_mode) |=> overflow_flag == $past(ovf_latch))
    else $error("overflow flag not from its comparator");

  a_oneshot_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
    (op_mode == OP_ONE_SHOT && !load_out) |=> $stable(conversion_result_bits))
    else $error("one-shot result changed without conversion");

  a_reserved_idle: assert property (@(posedge sys_clk) disable iff (rst) // RULE_12
    (op_mode == OP_RESERVED) |-> !sample_end && !sample_start)
    else $error("conversion activity in reserved mode");

  a_phase_swap: assert property (@(posedge sys_clk) disable iff (rst) // RULE_17
    (pipe_mode && ctrl_conv_en && phase_f && fall_ev) |-> sample_end && !sample_start)
    else $error("phase select did not invert sampling");

  a_oe_data: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
    conversion_result_oe == (global_output_enable && !data_output_enable_n)
    && overflow_flag_oe == global_output_enable)
    else $error("output enable truth table violated");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    ev[`EV_DONE_BIT] && irq_mask[`EV_DONE_BIT] |=> irq)
    else $error("unmasked event did not raise interrupt");

endmodule : flash_adc_output_timing

// File: tb/capture_model.sv
// Downstream logic that captures the converter output word
`timescale 1ns/1ps

module capture_model #(
  parameter int BITS = 6
) (
  input  wire logic            sample_clk,
  input  wire logic [BITS-1:0] bus_bits,
  input  wire logic            bus_ovf,
  output logic      [BITS-1:0] held_bits,
  output logic                 held_ovf
);
  // Falling edge keeps clear of the output update after the sample start
  // Same instant a latch enabled on clock-high would close
  always_ff @(negedge sample_clk) begin
    held_bits <= bus_bits;
    held_ovf  <= bus_ovf;
  end
endmodule : capture_model

// File: tb/flash_adc_output_timing_tb.sv
// Self-checking bench for the converter timing block
`timescale 1ns/1ps
`include "flash_adc_params.svh"

module flash_adc_output_timing_tb;
  import flash_adc_pkg::*;
  typedef struct { int n; logic ovf; logic [5:0] code; } row_s;
  logic sys_clk, rst, sample_clk, mode_pipelined, phase_select;
  logic [62:0] comparator_levels;
  logic overflow_comparator, data_output_enable_n, global_output_enable;
  logic [5:0] conversion_result_bits, bus_bits, held_bits;
  logic conversion_result_oe, overflow_flag, overflow_flag_oe, bus_ovf, held_ovf;
  logic hsel, hwrite, hreadyout, hresp, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  int num_errors, n_tests;
  row_s rows [6] = '{'{0, 1'b0, 6'h00}, '{1, 1'b0, 6'h01}, '{31, 1'b1, 6'h1f},
                     '{32, 1'b0, 6'h20}, '{62, 1'b0, 6'h3e}, '{63, 1'b1, 6'h3f}};
  // Released lines show the inverse, so a stale value cannot pass
  assign bus_bits = conversion_result_oe ? conversion_result_bits : ~conversion_result_bits;
  assign bus_ovf  = overflow_flag_oe ? overflow_flag : ~overflow_flag;

  flash_adc_output_timing dut (.sys_clk(sys_clk), .rst(rst), .sample_clk(sample_clk),
    .mode_pipelined(mode_pipelined), .phase_select(phase_select),
    .comparator_levels(comparator_levels), .overflow_comparator(overflow_comparator),
    .data_output_enable_n(data_output_enable_n), .global_output_enable(global_output_enable),
    .conversion_result_bits(conversion_result_bits), .conversion_result_oe(conversion_result_oe),
    .overflow_flag(overflow_flag), .overflow_flag_oe(overflow_flag_oe), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));
  capture_model cap (.sample_clk(sample_clk), .bus_bits(bus_bits), .bus_ovf(bus_ovf),
    .held_bits(held_bits), .held_ovf(held_ovf));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task summarize;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for hready at the next rising edges
  task hwait;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        num_errors++;
        summarize();
      end
      @(posedge sys_clk);
    end
  endtask : hwait

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask : ahb

  // Sample clock pulses of 20 system cycles a half, idle low between frames
  task sclk(input int cnt);
    repeat (cnt) begin
      sample_clk <= 1'b1;
      repeat (20) @(posedge sys_clk);
      sample_clk <= 1'b0;
      repeat (20) @(posedge sys_clk);
    end
  endtask : sclk

  function automatic logic [62:0] therm(input int n);
    logic [62:0] t;
    t = '0;
    for (int i = 0; i < n; i++) t[i] = 1'b1;
    return t;
  endfunction : therm

  initial begin
    num_errors = 0;
    n_tests = 0;
    {rst, sample_clk, mode_pipelined, phase_select} = 4'b1010;
    {comparator_levels, overflow_comparator} = '0;
    {data_output_enable_n, global_output_enable} = 2'b01;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values and an unmapped place
    ahb(1'b0, `CTRL_OFF, 32'h0);
    chk(r, `CTRL_RESET_VAL);
    ahb(1'b0, `IRQ_MASK_OFF, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    chk({irq, conversion_result_bits}, 7'h00);
    chk({hreadyout, hresp}, 2'b10);
    // Pipelined conversions over the code range
    foreach (rows[i]) begin
      comparator_levels <= therm(rows[i].n);
      overflow_comparator <= rows[i].ovf;
      sclk(3);
      chk(conversion_result_bits, rows[i].code);
      chk(overflow_flag, rows[i].ovf);
      chk({held_ovf, held_bits}, {rows[i].ovf, rows[i].code});
      chk(bus_bits, held_bits);
    end
    ahb(1'b0, `RESULT_OFF, 32'h0);
    chk(r, 32'h7f);
    // Enable truth table, checked off the clock edge
    for (int i = 0; i < 4; i++) begin
      data_output_enable_n <= i[0];
      global_output_enable <= i[1];
      @(posedge sys_clk);
      #1;
      chk({conversion_result_oe, overflow_flag_oe}, {i[1] & ~i[0], i[1]});
    end
    // Phase high inverts the phases in pipelined mode
    phase_select <= 1'b1;
    comparator_levels <= therm(5);
    overflow_comparator <= 1'b0;
    sclk(3);
    chk(conversion_result_bits, 6'h05);
    // Clear events, then unmask only the reserved-mode event
    ahb(1'b1, `IRQ_STATUS_OFF, 32'h7);
    ahb(1'b0, `IRQ_STATUS_OFF, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, `IRQ_MASK_OFF, 32'h4);
    chk(irq, 1'b0);
    // Reserved combination: no load, event raised
    mode_pipelined <= 1'b0;
    comparator_levels <= therm(9);
    sclk(1);
    chk(conversion_result_bits, 6'h05);
    chk(irq, 1'b1);
    ahb(1'b1, `IRQ_STATUS_OFF, 32'h4);
    #1;
    chk(irq, 1'b0);
    // One-shot: one pulse converts, then the result holds
    phase_select <= 1'b0;
    sclk(1);
    chk(conversion_result_bits, 6'h09);
    comparator_levels <= therm(20);
    repeat (40) @(posedge sys_clk);
    chk(conversion_result_bits, 6'h09);
    summarize();
  end
endmodule : flash_adc_output_timing_tb
